// >>> include/pdf_pkg.sv
// Overview of operation
// - Legacy mode resets port C direction so its pins drive push-pull low.
// - Port C, D and E pins take their reset state while reset is high, with no clock.
// - Port D output register: eight read/write bits, cleared by reset.
// - Port D direction register: eight read/write bits, cleared by reset.
// - Port E output register: eight read/write bits, cleared by reset.
// - Port E direction register: eight read/write bits, cleared by reset.
// - Port F output register: eight read/write bits, cleared by reset.
package pdf_pkg;

    // ==========================================================
    // Widths
    localparam int PDF_PORT_W = 8;
    localparam int PDF_DATA_W = 32;
    localparam int PDF_ADDR_W = 8;

    // ==========================================================
    // Register byte offsets
    localparam logic [PDF_ADDR_W-1:0] PDF_OFS_C_DIR = 8'h00;
    localparam logic [PDF_ADDR_W-1:0] PDF_OFS_C_SAMPLE = 8'h04;
    localparam logic [PDF_ADDR_W-1:0] PDF_OFS_D_OUT = 8'h08;
    localparam logic [PDF_ADDR_W-1:0] PDF_OFS_D_DIR = 8'h0C;
    localparam logic [PDF_ADDR_W-1:0] PDF_OFS_D_SAMPLE = 8'h10;
    localparam logic [PDF_ADDR_W-1:0] PDF_OFS_E_OUT = 8'h14;
    localparam logic [PDF_ADDR_W-1:0] PDF_OFS_E_DIR = 8'h18;
    localparam logic [PDF_ADDR_W-1:0] PDF_OFS_E_SAMPLE = 8'h1C;
    localparam logic [PDF_ADDR_W-1:0] PDF_OFS_F_OUT = 8'h20;
    localparam logic [PDF_ADDR_W-1:0] PDF_OFS_STATUS = 8'h24;

    // ==========================================================
    // Reset values and fields
    localparam logic [PDF_PORT_W-1:0] PDF_RST_ZERO = 8'h00;
    localparam logic [PDF_PORT_W-1:0] PDF_RST_ALL_OUT = 8'hFF;
    localparam int PDF_STATUS_LEGACY_BIT = 0;
    localparam int PDF_SEL_DATA_LANE = 0;

    typedef enum logic [3:0] {
        PDF_REG_C_DIR,
        PDF_REG_C_SAMPLE,
        PDF_REG_D_OUT,
        PDF_REG_D_DIR,
        PDF_REG_D_SAMPLE,
        PDF_REG_E_OUT,
        PDF_REG_E_DIR,
        PDF_REG_E_SAMPLE,
        PDF_REG_F_OUT,
        PDF_REG_STATUS,
        PDF_REG_NONE
    } pdf_reg_t;

endpackage

// >>> src/pdf_pin_stage.sv
`timescale 1ns/100ps
module pdf_pin_stage
    import pdf_pkg::*;
#(
    parameter int WIDTH = PDF_PORT_W
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pin side
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] pin_o,
    output logic [WIDTH-1:0] pin_oe_o,
    // Register side
    input wire logic [WIDTH-1:0] drive_val_i,
    input wire logic [WIDTH-1:0] drive_en_i,
    input wire logic [WIDTH-1:0] reset_val_i,
    input wire logic [WIDTH-1:0] reset_en_i,
    output logic [WIDTH-1:0] sample_o
);

    typedef struct packed {
        logic [WIDTH-1:0] sample;
    } pdf_stage_state_t;

    pdf_stage_state_t state_reg;
    pdf_stage_state_t state_next;

    if (WIDTH < 1)
    begin : g_width
        $error("pdf_pin_stage: WIDTH must be at least 1");
    end

    // ==========================================================
    // Sampling
    // No reset on the sample: it simply follows the pins
    always_comb
    begin
        state_next = state_reg;
        state_next.sample = pin_i;
    end

    always_ff @(posedge clk_i)
    begin
        state_reg <= state_next;
    end

    assign sample_o = state_reg.sample;

    // ==========================================================
    // Drive
    // Reset overrides the pins combinationally so a stopped clock still applies it
    always_comb
    begin
        if (rst_i)
        begin
            pin_o = reset_val_i;
            pin_oe_o = reset_en_i;
        end
        else
        begin
            pin_o = drive_val_i;
            pin_oe_o = drive_en_i;
        end
    end

endmodule

// >>> src/pdf_port_regs.sv
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/100ps
module pdf_port_regs
    import pdf_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,

    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [PDF_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [PDF_DATA_W-1:0] wb_dat_i,
    output logic [PDF_DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,

    // Legacy compatibility strap
    input wire logic legacy_mode_i,

    // Port C pins
    input wire logic [PDF_PORT_W-1:0] port_c_pin_i,
    output logic [PDF_PORT_W-1:0] port_c_pin_o,
    output logic [PDF_PORT_W-1:0] port_c_pin_oe_o,

    // Port D pins
    input wire logic [PDF_PORT_W-1:0] port_d_pin_i,
    output logic [PDF_PORT_W-1:0] port_d_pin_o,
    output logic [PDF_PORT_W-1:0] port_d_pin_oe_o,

    // Port E pins
    input wire logic [PDF_PORT_W-1:0] port_e_pin_i,
    output logic [PDF_PORT_W-1:0] port_e_pin_o,
    output logic [PDF_PORT_W-1:0] port_e_pin_oe_o,

    // Port F output value
    output logic [PDF_PORT_W-1:0] port_f_out_o
);

    // ==========================================================
    // State
    typedef struct packed {
        logic ack;
        logic err;
        logic [PDF_DATA_W-1:0] rdata;
        logic legacy;
        logic [PDF_PORT_W-1:0] c_dir;
        logic [PDF_PORT_W-1:0] d_out;
        logic [PDF_PORT_W-1:0] d_dir;
        logic [PDF_PORT_W-1:0] e_out;
        logic [PDF_PORT_W-1:0] e_dir;
        logic [PDF_PORT_W-1:0] f_out;
    } pdf_state_t;

    pdf_state_t state_reg;
    pdf_state_t state_next;

    logic [PDF_PORT_W-1:0] c_sample;
    logic [PDF_PORT_W-1:0] d_sample;
    logic [PDF_PORT_W-1:0] e_sample;
    logic [PDF_PORT_W-1:0] c_reset_dir;
    pdf_reg_t sel_hit;
    logic req;
    logic lane_ok;
    logic take;
    logic wr_fire;

    // ==========================================================
    // Elaboration checks
    // Every register must fit within one bus word
    if (PDF_PORT_W > PDF_DATA_W)
    begin : g_port_width
        $error("pdf_port_regs: port width exceeds bus width");
    end
    if (PDF_STATUS_LEGACY_BIT >= PDF_DATA_W)
    begin : g_status_bit
        $error("pdf_port_regs: status bit lies outside the bus word");
    end
    if (PDF_SEL_DATA_LANE >= PDF_DATA_W / 8)
    begin : g_data_lane
        $error("pdf_port_regs: data lane lies outside the byte selects");
    end

    // ==========================================================
    // Helpers
    function automatic pdf_reg_t pdf_decode(input logic [PDF_ADDR_W-1:0] adr);
        pdf_reg_t r;
        r = PDF_REG_NONE;
        if (adr == PDF_OFS_C_DIR)
        begin
            r = PDF_REG_C_DIR;
        end
        else if (adr == PDF_OFS_C_SAMPLE)
        begin
            r = PDF_REG_C_SAMPLE;
        end
        else if (adr == PDF_OFS_D_OUT)
        begin
            r = PDF_REG_D_OUT;
        end
        else if (adr == PDF_OFS_D_DIR)
        begin
            r = PDF_REG_D_DIR;
        end
        else if (adr == PDF_OFS_D_SAMPLE)
        begin
            r = PDF_REG_D_SAMPLE;
        end
        else if (adr == PDF_OFS_E_OUT)
        begin
            r = PDF_REG_E_OUT;
        end
        else if (adr == PDF_OFS_E_DIR)
        begin
            r = PDF_REG_E_DIR;
        end
        else if (adr == PDF_OFS_E_SAMPLE)
        begin
            r = PDF_REG_E_SAMPLE;
        end
        else if (adr == PDF_OFS_F_OUT)
        begin
            r = PDF_REG_F_OUT;
        end
        else if (adr == PDF_OFS_STATUS)
        begin
            r = PDF_REG_STATUS;
        end
        return r;
    endfunction

    // Byte data sits in the low lane, upper bits read as zero
    function automatic logic [PDF_DATA_W-1:0] pdf_widen(input logic [PDF_PORT_W-1:0] v);
        return {{(PDF_DATA_W-PDF_PORT_W){1'b0}}, v};
    endfunction

    // Legacy mode resets every port C pin to an output
    function automatic logic [PDF_PORT_W-1:0] pdf_c_reset(input logic legacy);
        return legacy ? PDF_RST_ALL_OUT : PDF_RST_ZERO;
    endfunction

    // Read word of a decoded register; upper lanes read as zero
    function automatic logic [PDF_DATA_W-1:0] pdf_read_word(
        input pdf_reg_t sel,
        input pdf_state_t st,
        input logic [PDF_PORT_W-1:0] c_smp,
        input logic [PDF_PORT_W-1:0] d_smp,
        input logic [PDF_PORT_W-1:0] e_smp
    );
        logic [PDF_DATA_W-1:0] w;
        w = '0;
        if (sel == PDF_REG_C_DIR)
        begin
            w = pdf_widen(st.c_dir);
        end
        else if (sel == PDF_REG_C_SAMPLE)
        begin
            w = pdf_widen(c_smp);
        end
        else if (sel == PDF_REG_D_OUT)
        begin
            w = pdf_widen(st.d_out);
        end
        else if (sel == PDF_REG_D_DIR)
        begin
            w = pdf_widen(st.d_dir);
        end
        else if (sel == PDF_REG_D_SAMPLE)
        begin
            w = pdf_widen(d_smp);
        end
        else if (sel == PDF_REG_E_OUT)
        begin
            w = pdf_widen(st.e_out);
        end
        else if (sel == PDF_REG_E_DIR)
        begin
            w = pdf_widen(st.e_dir);
        end
        else if (sel == PDF_REG_E_SAMPLE)
        begin
            w = pdf_widen(e_smp);
        end
        else if (sel == PDF_REG_F_OUT)
        begin
            w = pdf_widen(st.f_out);
        end
        else if (sel == PDF_REG_STATUS)
        begin
            w[PDF_STATUS_LEGACY_BIT] = st.legacy;
        end
        return w;
    endfunction

    // Byte write into the addressed register; read-only targets keep their value
    function automatic pdf_state_t pdf_write_state(
        input pdf_state_t st,
        input pdf_reg_t sel,
        input logic [PDF_PORT_W-1:0] val
    );
        pdf_state_t s;
        s = st;
        if (sel == PDF_REG_C_DIR)
        begin
            s.c_dir = val;
        end
        else if (sel == PDF_REG_D_OUT)
        begin
            s.d_out = val;
        end
        else if (sel == PDF_REG_D_DIR)
        begin
            s.d_dir = val;
        end
        else if (sel == PDF_REG_E_OUT)
        begin
            s.e_out = val;
        end
        else if (sel == PDF_REG_E_DIR)
        begin
            s.e_dir = val;
        end
        else if (sel == PDF_REG_F_OUT)
        begin
            s.f_out = val;
        end
        return s;
    endfunction

    // Reset image; the status bit catches the strap on the clocked reset, while the port C pins follow it without a clock
    function automatic pdf_state_t pdf_reset_state(
        input logic strap,
        input logic [PDF_PORT_W-1:0] c_dir
    );
        pdf_state_t s;
        s = '0;
        s.legacy = strap;
        s.c_dir = c_dir;
        s.d_out = PDF_RST_ZERO;
        s.d_dir = PDF_RST_ZERO;
        s.e_out = PDF_RST_ZERO;
        s.e_dir = PDF_RST_ZERO;
        s.f_out = PDF_RST_ZERO;
        return s;
    endfunction

    assign sel_hit = pdf_decode(wb_adr_i);
    assign req = wb_cyc_i && wb_stb_i;
    assign lane_ok = wb_sel_i[PDF_SEL_DATA_LANE];
    assign c_reset_dir = pdf_c_reset(legacy_mode_i);
    // Taken only while no answer stands, so a held strobe is not taken twice
    assign take = req && !state_reg.ack && !state_reg.err;
    // Writes land on the edge where the master sees ack
    assign wr_fire = req && state_reg.ack && wb_we_i && lane_ok;

    // ==========================================================
    // Next state
    always_comb
    begin
        state_next = state_reg;
        state_next.ack = 1'b0;
        state_next.err = 1'b0;

        // Answer one edge after the request, drop the next edge
        if (take)
        begin
            if (sel_hit == PDF_REG_NONE)
            begin
                state_next.err = 1'b1;
                state_next.rdata = '0;
            end
            else
            begin
                state_next.ack = 1'b1;
                state_next.rdata = pdf_read_word(sel_hit, state_reg, c_sample, d_sample,
                    e_sample);
            end
        end

        if (wr_fire)
        begin
            state_next = pdf_write_state(state_next, sel_hit, wb_dat_i[PDF_PORT_W-1:0]);
        end

        if (rst_i)
        begin
            state_next = pdf_reset_state(legacy_mode_i, c_reset_dir);
        end
    end

    always_ff @(posedge clk_i)
    begin
        state_reg <= state_next;
    end

    // ==========================================================
    // Bus outputs
    assign wb_ack_o = state_reg.ack;
    assign wb_err_o = state_reg.err;
    assign wb_dat_o = state_reg.rdata;
    assign port_f_out_o = state_reg.f_out;

    // ==========================================================
    // Pin stages
    // Port C only ever drives low; its direction picks which pins drive
    pdf_pin_stage #(
        .WIDTH(PDF_PORT_W)
    ) u_port_c (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(port_c_pin_i),
        .pin_o(port_c_pin_o),
        .pin_oe_o(port_c_pin_oe_o),
        .drive_val_i(PDF_RST_ZERO),
        .drive_en_i(state_reg.c_dir),
        .reset_val_i(PDF_RST_ZERO),
        .reset_en_i(c_reset_dir),
        .sample_o(c_sample)
    );

    pdf_pin_stage #(
        .WIDTH(PDF_PORT_W)
    ) u_port_d (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(port_d_pin_i),
        .pin_o(port_d_pin_o),
        .pin_oe_o(port_d_pin_oe_o),
        .drive_val_i(state_reg.d_out),
        .drive_en_i(state_reg.d_dir),
        .reset_val_i(PDF_RST_ZERO),
        .reset_en_i(PDF_RST_ZERO),
        .sample_o(d_sample)
    );

    pdf_pin_stage #(
        .WIDTH(PDF_PORT_W)
    ) u_port_e (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(port_e_pin_i),
        .pin_o(port_e_pin_o),
        .pin_oe_o(port_e_pin_oe_o),
        .drive_val_i(state_reg.e_out),
        .drive_en_i(state_reg.e_dir),
        .reset_val_i(PDF_RST_ZERO),
        .reset_en_i(PDF_RST_ZERO),
        .sample_o(e_sample)
    );

endmodule

// >>> test/pdf_port_regs_asserts.sv
`timescale 1ns/100ps
module pdf_port_regs_chk
    import pdf_pkg::*;
(
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [PDF_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [PDF_DATA_W-1:0] wb_dat_i,
    input wire logic [PDF_DATA_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    // Strap and pins
    input wire logic legacy_mode_i,
    input wire logic [PDF_PORT_W-1:0] port_d_pin_i,
    input wire logic [PDF_PORT_W-1:0] port_c_pin_o,
    input wire logic [PDF_PORT_W-1:0] port_c_pin_oe_o,
    input wire logic [PDF_PORT_W-1:0] port_d_pin_o,
    input wire logic [PDF_PORT_W-1:0] port_d_pin_oe_o,
    input wire logic [PDF_PORT_W-1:0] port_e_pin_o,
    input wire logic [PDF_PORT_W-1:0] port_e_pin_oe_o,
    input wire logic [PDF_PORT_W-1:0] port_f_out_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    logic wr;
    logic rd;
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && !wb_err_o;
    // ==========================================
    // Reset state, checked without disable
    a_c_drive_low: assert property (port_c_pin_o == 8'h00)
        else $error("port C drives high");
    a_legacy_oe: assert property (rst_i && legacy_mode_i |-> port_c_pin_oe_o == 8'hFF)
        else $error("port C not all outputs in reset");
    a_c_oe_plain: assert property (rst_i && !legacy_mode_i |-> port_c_pin_oe_o == '0)
        else $error("port C drives in plain reset");
    a_rst_pins_off: assert property (rst_i |-> {port_d_pin_o, port_d_pin_oe_o,
        port_e_pin_o, port_e_pin_oe_o} == 32'h0) else $error("pins active in reset");
    // ==========================================
    // Register writes reach the pins; port D sample reads return the pins
    a_d_out_wr: assert property (disable iff (rst_i) wr && wb_adr_i == PDF_OFS_D_OUT
        |=> port_d_pin_o == $past(wb_dat_i[7:0])) else $error("port D output lost");
    a_d_dir_wr: assert property (disable iff (rst_i) wr && wb_adr_i == PDF_OFS_D_DIR
        |=> port_d_pin_oe_o == $past(wb_dat_i[7:0])) else $error("port D direction lost");
    a_e_out_wr: assert property (disable iff (rst_i) wr && wb_adr_i == PDF_OFS_E_OUT
        |=> port_e_pin_o == $past(wb_dat_i[7:0])) else $error("port E output lost");
    a_e_dir_wr: assert property (disable iff (rst_i) wr && wb_adr_i == PDF_OFS_E_DIR
        |=> port_e_pin_oe_o == $past(wb_dat_i[7:0])) else $error("port E direction lost");
    a_f_out_wr: assert property (disable iff (rst_i) wr && wb_adr_i == PDF_OFS_F_OUT
        |=> port_f_out_o == $past(wb_dat_i[7:0])) else $error("port F output lost");
    a_d_sample_rd: assert property (disable iff (rst_i) rd && wb_adr_i == PDF_OFS_D_SAMPLE
        |=> wb_ack_o && wb_dat_o[7:0] == $past(port_d_pin_i, 2)) else $error("bad D sample");
    c_write: cover property (wr);
    c_err: cover property (wb_err_o);
    c_sample: cover property (rd && wb_adr_i == PDF_OFS_D_SAMPLE);
endmodule
bind pdf_port_regs pdf_port_regs_chk i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .legacy_mode_i,
    .port_d_pin_i, .port_c_pin_o, .port_c_pin_oe_o, .port_d_pin_o, .port_d_pin_oe_o,
    .port_e_pin_o, .port_e_pin_oe_o, .port_f_out_o);

// >>> test/tb.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
    begin checks++; if ((got) !== (ex)) begin fail_count++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module tb
    import pdf_pkg::*;
;
    logic clk_i, rst_i, clk_run, cyc, stb, we, legacy, er;
    logic [7:0] adr, pc, pd, pe, v, c_oe, d_o, d_oe, e_o, e_oe, f_o;
    logic [3:0] sel;
    logic [31:0] dat, dat_o, rd;
    logic ack, err;
    int fail_count, checks;
    logic [7:0] tab [6] = '{PDF_OFS_C_DIR, PDF_OFS_D_OUT, PDF_OFS_D_DIR,
        PDF_OFS_E_OUT, PDF_OFS_E_DIR, PDF_OFS_F_OUT};
    pdf_port_regs i_pdf_port_regs (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .wb_err_o(err), .legacy_mode_i(legacy), .port_c_pin_i(pc),
        .port_c_pin_o(), .port_c_pin_oe_o(c_oe), .port_d_pin_i(pd), .port_d_pin_o(d_o),
        .port_d_pin_oe_o(d_oe), .port_e_pin_i(pe), .port_e_pin_o(e_o),
        .port_e_pin_oe_o(e_oe), .port_f_out_o(f_o));
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = clk_run ? ~clk_i : clk_i;
    end
    function automatic logic [7:0] pin_of(int i);
        logic [7:0] p [6] = '{c_oe, d_o, d_oe, e_o, e_oe, f_o};
        return p[i];
    endfunction
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Classic single cycle; call right after a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
        input logic [3:0] s);
        int n;
        n = 0;
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, 24'h0, d, s};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        rd = dat_o;
        er = err;
        {cyc, stb} <= 2'b00;
        @(posedge clk_i);
        if (n >= 20)
        begin
            $display("[ERR] bus answer exp 1 got 0");
            fail_count++;
            stop_test();
        end
    endtask
    task automatic chk_rst(input logic leg);
        for (int i = 0; i < 6; i++)
        begin
            wb(1'b0, tab[i], 8'h00, 4'hF);
            `CHK("reset value", (i == 0 && leg) ? 32'hFF : 32'h0, rd)
        end
        wb(1'b0, PDF_OFS_STATUS, 8'h00, 4'hF);
        `CHK("status", {31'h0, leg}, rd)
        $display("test reset_values done");
    endtask
    initial
    begin
        void'($urandom(32'h2f63));
        clk_run = 1'b1;
        rst_i = 1'b1;
        legacy = 1'b1;
        {cyc, stb, we, adr, dat, sel} = '0;
        {pc, pd, pe, fail_count, checks} = '0;
        repeat (4) @(posedge clk_i);
        `CHK("legacy oe", 8'hFF, c_oe)
        rst_i <= 1'b0;
        // Legacy-minded software leaves port C alone; its pins keep driving low
        for (int i = 1; i < 6; i++)
            wb(1'b1, tab[i], 8'h00, 4'hF);
        `CHK("legacy oe held", 8'hFF, c_oe)
        $display("test legacy_compat done");
        chk_rst(1'b1);
        // Random writes, readback, and a write with lane 0 deselected
        repeat (4)
            for (int i = 0; i < 6; i++)
            begin
                v = 8'($urandom);
                wb(1'b1, tab[i], v, 4'hF);
                `CHK("pin", v, pin_of(i))
                wb(1'b1, tab[i], ~v, 4'hE);
                wb(1'b0, tab[i], 8'h00, 4'hF);
                `CHK("readback", {24'h0, v}, rd)
            end
        $display("test rw_random done");
        repeat (4)
        begin
            {pc, pd, pe} <= 24'($urandom);
            repeat (2) @(posedge clk_i);
            wb(1'b1, PDF_OFS_D_SAMPLE, ~pd, 4'hF);
            wb(1'b0, PDF_OFS_D_SAMPLE, 8'h00, 4'hF);
            `CHK("d sample", {24'h0, pd}, rd)
            wb(1'b0, PDF_OFS_E_SAMPLE, 8'h00, 4'hF);
            `CHK("e sample", {24'h0, pe}, rd)
            wb(1'b0, PDF_OFS_C_SAMPLE, 8'h00, 4'hF);
            `CHK("c sample", {24'h0, pc}, rd)
        end
        wb(1'b0, 8'hFC, 8'h00, 4'hF);
        `CHK("unmapped", 33'h100000000, {er, rd})
        $display("test samples done");
        // Park every register high, then reset with the clock stopped
        for (int i = 0; i < 6; i++)
            wb(1'b1, tab[i], 8'hFF, 4'hF);
        clk_run = 1'b0;
        #1 {rst_i, legacy} = 2'b10;
        #1 `CHK("pins stopped clock", 40'h0, {c_oe, d_o, d_oe, e_o, e_oe})
        $display("test stopped_clock done");
        clk_run = 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        chk_rst(1'b0);
        stop_test();
    end
endmodule
